//--- design/touch_regs_pkg.sv
// constants and types shared by the touch threshold control registers
package touch_regs_pkg;
  localparam int NUM_CHANNELS = 8;
  localparam int LEVEL_W = 3;
  localparam int THRESH_W = 11;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h78;
  localparam logic [7:0] OFS_THRESHOLD_BASE = 8'h00;
  localparam logic [7:0] OFS_THRESHOLD_INCREMENT = 8'h01;
  localparam logic [7:0] OFS_LEVEL_CH0_CH1 = 8'h02;
  localparam logic [7:0] OFS_LEVEL_CH6_CH7 = 8'h05;
  localparam logic [7:0] OFS_SCAN_MODE_CONTROL = 8'h06;
  localparam logic [7:0] OFS_POWER_RESET_CONTROL = 8'h07;
  localparam logic [7:0] RST_THRESHOLD_BASE = 8'h14;
  localparam logic [7:0] RST_THRESHOLD_INCREMENT = 8'h14;
  localparam logic [7:0] RST_LEVEL_PAIR = 8'h33;
  localparam logic [7:0] RST_SCAN_MODE_CONTROL = 8'h80;
  localparam logic [7:0] RST_POWER_RESET_CONTROL = 8'h00;
  localparam logic [7:0] MASK_LEVEL_PAIR = 8'h77;
  localparam logic [7:0] MASK_SCAN_MODE_CONTROL = 8'h80;
  localparam logic [7:0] MASK_POWER_RESET_CONTROL = 8'h0C;
  localparam int EVEN_LEVEL_LSB = 0;
  localparam int ODD_LEVEL_LSB = 4;
  localparam int FAST_ONLY_BIT = 7;
  localparam int SOFT_RESET_BIT = 3;
  localparam int SLEEP_ENABLE_BIT = 2;
  typedef logic [LEVEL_W-1:0] level_t;
  typedef logic [THRESH_W-1:0] thresh_t;
endpackage

//--- design/reg_access_if.sv
// byte-wide register access between the serial slave and the register bank
`timescale 1ns/1ps
interface reg_access_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, input rdata);
  modport slave (input addr, input wdata, input wr, output rdata);
endinterface // reg_access_if

//--- design/i2c_byte_slave.sv
// serial slave: address pointer with auto increment, byte writes and reads
`timescale 1ns/1ps
module i2c_byte_slave
  import touch_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [6:0] slaveAddr,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  reg_access_if.master regs
);
  typedef enum logic [2:0] {IDLE, ADDR, ACK, PTR, WDATA, RDATA, RACK, LOAD} state_t;
  state_t state_q;
  logic sclPrev_q, sdaPrev_q, readMode_q, ackNext_q;
  logic [7:0] shift_q, ptr_q;
  logic [3:0] bitCnt_q;
  logic sclRise, sclFall, startSeen, stopSeen;
  state_t afterAck_q;
  assign sclRise = sclIn && !sclPrev_q;
  assign sclFall = !sclIn && sclPrev_q;
  assign startSeen = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
  assign stopSeen = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;
  assign regs.addr = ptr_q;
  assign regs.wdata = shift_q;
  assign sdaOut = 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IDLE;
      afterAck_q <= IDLE;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      bitCnt_q <= 4'h0;
      readMode_q <= 1'b0;
      ackNext_q <= 1'b0;
      sdaOe <= 1'b0;
      regs.wr <= 1'b0;
    end else if (clkEn) begin
      regs.wr <= 1'b0;
      if (startSeen) begin
        state_q <= ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state_q <= IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_q)
          IDLE: begin
            sdaOe <= 1'b0;
          end
          ADDR, PTR, WDATA: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaIn};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == ADDR) begin
                if (shift_q[7:1] == slaveAddr) begin
                  sdaOe <= 1'b1;
                  readMode_q <= shift_q[0];
                  afterAck_q <= shift_q[0] ? RDATA : PTR;
                  state_q <= ACK;
                end else begin
                  state_q <= IDLE;
                end
              end else begin
                sdaOe <= 1'b1;
                state_q <= ACK;
                afterAck_q <= WDATA;
                if (state_q == PTR) begin
                  ptr_q <= shift_q;
                end else begin
                  regs.wr <= 1'b1;
                end
              end
            end
          end
          ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state_q <= readMode_q ? LOAD : afterAck_q;
            end else if (regs.wr) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
          RDATA: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe <= 1'b0;
                bitCnt_q <= 4'h0;
                state_q <= RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe <= !shift_q[6];
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          RACK: begin
            if (sclRise) begin
              ackNext_q <= !sdaIn;
            end else if (sclFall) begin
              if (ackNext_q) begin
                ptr_q <= ptr_q + 8'h01;
                state_q <= LOAD;
              end else begin
                state_q <= IDLE;
              end
            end
          end
          // one cycle late so the read mux already follows the new pointer
          LOAD: begin
            shift_q <= regs.rdata;
            sdaOe <= !regs.rdata[7];
            bitCnt_q <= 4'h1;
            state_q <= RDATA;
          end
          default: state_q <= IDLE;
        endcase
      end
    end
  end
endmodule // i2c_byte_slave

//--- design/channel_threshold_calc.sv
// one channel threshold: base plus increment times level
`timescale 1ns/1ps
module channel_threshold_calc
  import touch_regs_pkg::*;
(
  input wire logic [7:0] base,
  input wire logic [7:0] increment,
  input wire touch_regs_pkg::level_t level,
  output touch_regs_pkg::thresh_t threshold
);
  // start plus step times level
  // widened before the product so a full step times seven cannot wrap
  assign threshold = thresh_t'({3'b000, base}) + thresh_t'(increment) * thresh_t'(level);
endmodule // channel_threshold_calc

//--- design/touch_threshold_control_regs.sv
// threshold and general control register bank with serial register access
// Overview of operation
// - base threshold register, reset twenty
// - step increment register, reset twenty
// - threshold equals base plus step times level
// - two 3-bit levels per level register
// - level zero most, seven least sensitive
// - levels reset to three, threshold eighty
// - base and step latched on level write
// - bit seven selects fast-only scanning
// - alternating mode plus sleep enables combo
// - fast-only mode never sleeps
// - soft reset clears digital and serial logic
// - bit two enables low power sleep
// - serial access, address auto increments
`timescale 1ns/1ps
module touch_threshold_control_regs
  import touch_regs_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [6:0] slaveAddr,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output touch_regs_pkg::thresh_t channelThreshold [CHANNELS],
  output logic fastOnlySelect,
  output logic sleepSensingCombo,
  output logic sleepActive,
  output logic softResetPulse
);
  if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
    $error("channel count must match the four level registers");
  end

  reg_access_if bus ();
  logic [7:0] thresholdBase_q, thresholdIncrement_q;
  logic [7:0] activeBase_q, activeIncrement_q;
  logic [7:0] levelPair_q [CHANNELS/2];
  logic [7:0] scanModeControl_q, powerResetControl_q;
  logic softRst_q, localRst;

  assign localRst = rst | softRst_q;

  function automatic logic isLevelAddr(input logic [7:0] a);
    return (a >= OFS_LEVEL_CH0_CH1) && (a <= OFS_LEVEL_CH6_CH7);
  endfunction

  i2c_byte_slave u_slave (
    .core_clk(core_clk),
    .rst(localRst),
    .clkEn(clkEn),
    .slaveAddr(slaveAddr),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .regs(bus.master)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      softRst_q <= 1'b0;
    end else if (clkEn) begin
      softRst_q <= bus.wr && bus.addr == OFS_POWER_RESET_CONTROL
                   && bus.wdata[SOFT_RESET_BIT];
    end
  end
  assign softResetPulse = softRst_q;

  always_ff @(posedge core_clk or posedge localRst) begin
    if (localRst) begin
      thresholdBase_q <= RST_THRESHOLD_BASE;
      thresholdIncrement_q <= RST_THRESHOLD_INCREMENT;
    end else if (clkEn && bus.wr) begin
      if (bus.addr == OFS_THRESHOLD_BASE) begin
        thresholdBase_q <= bus.wdata;
      end else if (bus.addr == OFS_THRESHOLD_INCREMENT) begin
        thresholdIncrement_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge localRst) begin
    if (localRst) begin
      activeBase_q <= RST_THRESHOLD_BASE;
      activeIncrement_q <= RST_THRESHOLD_INCREMENT;
    end else if (clkEn && bus.wr && isLevelAddr(bus.addr)) begin
      activeBase_q <= thresholdBase_q;
      activeIncrement_q <= thresholdIncrement_q;
    end
  end

  genvar p;
  generate
    for (p = 0; p < CHANNELS/2; p++) begin : g_pair
      always_ff @(posedge core_clk or posedge localRst) begin
        if (localRst) begin
          levelPair_q[p] <= RST_LEVEL_PAIR;
        end else if (clkEn && bus.wr && bus.addr == OFS_LEVEL_CH0_CH1 + 8'(p)) begin
          levelPair_q[p] <= bus.wdata & MASK_LEVEL_PAIR;
        end
      end
      channel_threshold_calc u_even (
        .base(activeBase_q),
        .increment(activeIncrement_q),
        .level(levelPair_q[p][EVEN_LEVEL_LSB +: LEVEL_W]),
        .threshold(channelThreshold[2*p])
      );
      channel_threshold_calc u_odd (
        .base(activeBase_q),
        .increment(activeIncrement_q),
        .level(levelPair_q[p][ODD_LEVEL_LSB +: LEVEL_W]),
        .threshold(channelThreshold[2*p+1])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or posedge localRst) begin
    if (localRst) begin
      scanModeControl_q <= RST_SCAN_MODE_CONTROL;
      powerResetControl_q <= RST_POWER_RESET_CONTROL;
    end else if (clkEn && bus.wr) begin
      if (bus.addr == OFS_SCAN_MODE_CONTROL) begin
        scanModeControl_q <= bus.wdata & MASK_SCAN_MODE_CONTROL;
      end else if (bus.addr == OFS_POWER_RESET_CONTROL) begin
        powerResetControl_q <= bus.wdata & MASK_POWER_RESET_CONTROL;
      end
    end
  end

  assign fastOnlySelect = scanModeControl_q[FAST_ONLY_BIT];
  assign sleepSensingCombo = !scanModeControl_q[FAST_ONLY_BIT]
                             && powerResetControl_q[SLEEP_ENABLE_BIT];
  assign sleepActive = sleepSensingCombo;

  always_comb begin
    if (bus.addr == OFS_THRESHOLD_BASE) begin
      bus.rdata = thresholdBase_q;
    end else if (bus.addr == OFS_THRESHOLD_INCREMENT) begin
      bus.rdata = thresholdIncrement_q;
    end else if (isLevelAddr(bus.addr)) begin
      bus.rdata = levelPair_q[2'(bus.addr - OFS_LEVEL_CH0_CH1)];
    end else if (bus.addr == OFS_SCAN_MODE_CONTROL) begin
      bus.rdata = scanModeControl_q;
    end else if (bus.addr == OFS_POWER_RESET_CONTROL) begin
      bus.rdata = powerResetControl_q;
    end else begin
      bus.rdata = 8'h00;
    end
  end
endmodule // touch_threshold_control_regs

//--- dv/touch_regs_asserts.sv
// port checker for the touch threshold register bank
`timescale 1ns/1ps
module touch_regs_asserts
  import touch_regs_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire touch_regs_pkg::thresh_t channelThreshold [CHANNELS],
  input wire logic fastOnlySelect,
  input wire logic sleepSensingCombo,
  input wire logic sleepActive,
  input wire logic softResetPulse
);
  logic [CHANNELS*THRESH_W-1:0] thrFlat;
  // flattened so one stability check covers every channel
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) thrFlat[i*THRESH_W +: THRESH_W] = channelThreshold[i];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
  pin_quiet_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved while scl high");
  reset_values_a: assert property ($fell(rst) |-> fastOnlySelect && !sleepActive
    && thrFlat == {CHANNELS{11'h050}}) else $error("wrong values after reset");
  fast_no_sleep_a: assert property (fastOnlySelect |-> !sleepActive && !sleepSensingCombo)
    else $error("sleep while fast only");
  combo_same_a: assert property (sleepActive == sleepSensingCombo)
    else $error("sleep outputs differ");
  pulse_single_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  pulse_on_ack_a: assert property (softResetPulse |-> sdaOe || $past(sdaOe) || $past(sdaOe, 2))
    else $error("soft reset without a write");
  soft_defaults_a: assert property (softResetPulse |-> ##[1:3] fastOnlySelect && !sleepActive
    && thrFlat == {CHANNELS{11'h050}}) else $error("soft reset left values");
  thresh_hold_a: assert property (!$stable(thrFlat) |-> sdaOe || $past(sdaOe)
    || $past(softResetPulse) || $past(softResetPulse, 2)) else $error("threshold moved alone");
endmodule // touch_regs_asserts
bind touch_threshold_control_regs touch_regs_asserts #(.CHANNELS(CHANNELS)) i_touch_regs_asserts (
  .core_clk, .rst, .sclIn, .sdaOut, .sdaOe, .channelThreshold, .fastOnlySelect,
  .sleepSensingCombo, .sleepActive, .softResetPulse);

//--- dv/touch_host_model.sv
// serial host model: drives the clock line and its own pull-down on data
`timescale 1ns/1ps
module touch_host_model (
  input wire logic core_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaHost
);
  // idle bus: both lines released to their pull-ups
  initial begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic start();
    tick(4);
    sdaHost = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaHost = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaHost = 1'b1;
  endtask
  // high phase four cycles so the oversampling slave sees it
  task automatic bitx(input logic b, output logic r);
    sdaHost = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    r = sdaLine;
    tick(2);
    scl = 1'b0;
    tick(4);
  endtask
  // byte msb first, then acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] r,
    output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ackOut, ack);
  endtask
endmodule // touch_host_model

//--- dv/touch_threshold_control_regs_tb_top.sv
// self-checking bench for the touch threshold register bank
`timescale 1ns/1ps
module touch_threshold_control_regs_tb_top;
  import touch_regs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclIn, sdaHost, sdaOut, sdaOe, fastOnlySelect, sleepSensingCombo, sleepActive;
  logic softResetPulse, ackBit;
  logic [7:0] q;
  thresh_t channelThreshold [NUM_CHANNELS];
  int mismatches = 0;
  int tests_run = 0;
  int seed = 32'h09FD2947;
  int cycles = 0;
  int pulses = 0;
  int regs [8];
  int dq [$];
  int base, step;
  // pull-up on data: low whenever either side pulls
  wire logic sdaLine = sdaHost & ~sdaOe;
  touch_threshold_control_regs i_touch_threshold_control_regs (.core_clk, .rst, .clkEn(1'b1),
    .slaveAddr(SLAVE_ADDR_DEFAULT), .sclIn, .sdaIn(sdaLine), .sdaOut, .sdaOe, .channelThreshold,
    .fastOnlySelect, .sleepSensingCombo, .sleepActive, .softResetPulse);
  touch_host_model i_touch_host_model (.core_clk, .sdaLine, .scl(sclIn), .sdaHost);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (softResetPulse === 1'b1) pulses++;
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [10:0] got, input int exp, input string what);
    tests_run++;
    if (got !== exp[10:0]) begin
      mismatches++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  function automatic int thr(int ch);
    return base + step * ((regs[2 + ch / 2] >> (4 * (ch % 2))) & 7);
  endfunction
  // soft reset bit is self-clearing, so the model never keeps it
  function automatic int wmask(int a);
    return a < 2 ? 8'hFF : a < 6 ? 8'h77 : a == 6 ? 8'h80 : 8'h04;
  endfunction
  task automatic model_reset();
    regs = '{8'h14, 8'h14, 8'h33, 8'h33, 8'h33, 8'h33, 8'h80, 8'h00};
    base = 8'h14;
    step = 8'h14;
  endtask
  task automatic send(input logic [7:0] d, input logic expAck);
    i_touch_host_model.xfer(d, 1'b1, q, ackBit);
    check(ackBit, !expAck, "acknowledge");
  endtask
  task automatic wr(input int a, input int n);
    i_touch_host_model.start();
    send({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1);
    send(a[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      send(dq[i][7:0], 1'b1);
      if (a + i < 8) regs[a + i] = dq[i] & wmask(a + i);
      if (a + i inside {[2:5]}) begin
        base = regs[0];
        step = regs[1];
      end
    end
    i_touch_host_model.stop();
  endtask
  task automatic rd(input int a, input int n);
    wr(a, 0);
    i_touch_host_model.start();
    send({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_touch_host_model.xfer(8'hFF, i == n - 1, q, ackBit);
      check(q, a + i < 8 ? regs[a + i] : 0, "read data");
    end
    i_touch_host_model.stop();
  endtask
  task automatic chk(input logic f, input logic s);
    for (int c = 0; c < NUM_CHANNELS; c++) check(channelThreshold[c], thr(c), "threshold");
    check({fastOnlySelect, sleepSensingCombo, sleepActive}, {f, !f && s, !f && s}, "mode");
  endtask
  initial begin
    model_reset();
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(1'b1, 1'b0);
    rd(0, 9);
    dq = '{$random(seed), $random(seed)};
    wr(0, 2);
    chk(1'b1, 1'b0);
    dq = '{$random(seed), $random(seed), $random(seed), $random(seed)};
    wr(2, 4);
    chk(1'b1, 1'b0);
    rd(0, 8);
    for (int k = 0; k < 8; k++) begin
      dq.delete();
      repeat (4) dq.push_back(k * 17 + 136);
      wr(2, 4);
      chk(1'b1, 1'b0);
    end
    for (int m = 0; m < 4; m++) begin
      dq = '{m / 2 * 8'h80 + 8'h7F, m % 2 * 8'h04 + 8'hF3};
      wr(6, 2);
      chk(m / 2, m % 2);
      rd(2, 6);
    end
    i_touch_host_model.start();
    send({SLAVE_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b0);
    i_touch_host_model.stop();
    i_touch_host_model.start();
    send({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1);
    send(8'h07, 1'b1);
    // acknowledge may be cut short by the reset, so it is not judged
    i_touch_host_model.xfer(8'h08, 1'b1, q, ackBit);
    i_touch_host_model.stop();
    model_reset();
    check(pulses, 1, "soft reset pulse");
    chk(1'b1, 1'b0);
    rd(0, 8);
    wrap_up();
  end
endmodule // touch_threshold_control_regs_tb_top
